// >>> common/pmir_consts.vh
`ifndef PMIR_CONSTS_VH
`define PMIR_CONSTS_VH

`define PMIR_HCLK_MHZ      50
`define PMIR_REF_MHZ       25
`define PMIR_REF_DIV       (`PMIR_HCLK_MHZ / (2 * `PMIR_REF_MHZ))
`define PMIR_STRAP_WAIT    2'h3

`define PMIR_MDIO_REG_INT  5'h1B
`define PMIR_MDIO_REG_CTL2 5'h1F
`define PMIR_POL_BIT       14
`define PMIR_ADDR_HI       2'h0
`define PMIR_PRE_LEN       6'h20
`define PMIR_HDR_LEN       4'hD
`define PMIR_DATA_LEN      5'h10
`define PMIR_OP_READ       2'h2
`define PMIR_OP_WRITE      2'h1

`define PMIR_A_CTRL        8'h00
`define PMIR_A_STRAP       8'h04
`define PMIR_A_IRQ_STAT    8'h08
`define PMIR_A_IRQ_MASK    8'h0C
`define PMIR_A_INT_STATE   8'h10

`define PMIR_CTRL_PME_SEL  0
`define PMIR_CTRL_WAKE_CLR 1
`define PMIR_EV_MDIO_WR    0
`define PMIR_EV_MDIO_RD    1
`define PMIR_EV_WAKE       2
`define PMIR_EV_STRAP      3
`define PMIR_EV_W          4

`endif

// >>> design/pmir_regmem.v
`timescale 1ns/1ps
module pmir_regmem (
    input  wire        hclk,
    input  wire        we,
    input  wire [4:0]  waddr,
    input  wire [15:0] wdata,
    input  wire [4:0]  raddr,
    output reg  [15:0] rdata_q
);
    reg [15:0] mem [0:31];

    always @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule // pmir_regmem

// >>> design/pmir_top.v
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pmir_consts.vh"
module pmir_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output wire        hirq,
    input  wire        mdc_i,
    input  wire        mdio_i,
    output reg         mdio_o,
    output reg         mdio_oe,
    output reg         wake_event_out,
    output wire        wake_event_out_oe,
    input  wire        ref_clk_in,
    output reg         ref_clk_out,
    output reg         ref_clk_out_oe,
    input  wire        ref_clk_out_i,
    input  wire [2:0]  mgmt_addr_strap,
    input  wire        clk_out_en_strap,
    input  wire [7:0]  phy_evt,
    input  wire        wake_evt
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_HDR  = 6'h02;
    localparam [5:0] S_TA   = 6'h04;
    localparam [5:0] S_RD   = 6'h08;
    localparam [5:0] S_WR   = 6'h10;
    localparam [5:0] S_DONE = 6'h20;

    function [31:0] fld;
        input [31:0] v;
        input integer w;
        begin
            fld = v & ((32'h1 << w) - 32'h1);
        end
    endfunction

    // Pin synchronisers: mdc, mdio, five strap levels
    reg  [6:0] s1_q;
    reg  [6:0] s2_q;
    reg  [6:0] s3_q;
    reg  [6:0] lvl_q;
    wire [6:0] pin_raw = {mdc_i, mdio_i, ref_clk_out_i, clk_out_en_strap, mgmt_addr_strap};
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : g_sync
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    lvl_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        lvl_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate
    wire mdc_rise = (s2_q[6] == s3_q[6]) && s3_q[6] && !lvl_q[6];
    wire mdio_in  = lvl_q[5];

    // Strap capture after release of reset
    reg [1:0] strap_cnt_q;
    reg       strap_done_q;
    reg [2:0] addr_strap_q;
    reg       led_strap_q;
    reg       clk_en_strap_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cnt_q    <= 2'h0;
            strap_done_q   <= 1'b0;
            addr_strap_q   <= 3'h0;
            led_strap_q    <= 1'b0;
            clk_en_strap_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == `PMIR_STRAP_WAIT) begin
                strap_done_q   <= 1'b1;
                // Third stage agrees with the second by now; level stage lags one more
                addr_strap_q   <= s3_q[2:0];
                led_strap_q    <= s3_q[4];
                clk_en_strap_q <= s3_q[3];
            end
        end
    end
    wire [4:0] my_addr = {`PMIR_ADDR_HI, addr_strap_q};

    // Reference clock from core clock divider
    reg [7:0] ref_div_q;
    wire [31:0] ref_last = fld(`PMIR_REF_DIV - 1, 8);
    wire      ref_tick = (ref_div_q == ref_last[7:0]);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_div_q      <= 8'h00;
            ref_clk_out    <= 1'b0;
            ref_clk_out_oe <= 1'b0;
        end else begin
            ref_div_q <= ref_tick ? 8'h00 : ref_div_q + 8'h01;
            ref_clk_out_oe <= strap_done_q;
            if (ref_tick && clk_en_strap_q) begin
                ref_clk_out <= ~ref_clk_out;
            end
        end
    end

    // Management frame engine
    reg [5:0]  st_q;
    reg [5:0]  ones_q;
    reg [4:0]  cnt_q;
    reg [12:0] hdr_q;
    reg [15:0] sh_q;
    reg        is_rd_q;
    reg        mem_we;
    reg        rd_ev;
    reg        wr_ev;
    wire [15:0] mem_rdata;
    reg  [7:0] int_en_q;
    reg  [7:0] int_st_q;
    reg        int_pol_q;
    wire [4:0] reg_a   = hdr_q[4:0];
    wire [12:0] hdr_n  = {hdr_q[11:0], mdio_in};
    // Status cleared at the edge that loads it for shifting out
    wire       int_rd  = mdc_rise && strap_done_q && st_q == S_TA && is_rd_q
                         && (reg_a == `PMIR_MDIO_REG_INT);
    wire       int_wr  = mem_we && (reg_a == `PMIR_MDIO_REG_INT);
    wire       pol_wr  = mem_we && (reg_a == `PMIR_MDIO_REG_CTL2);

    pmir_regmem u_mem (
        .hclk    (hclk),
        .we      (mem_we),
        .waddr   (reg_a),
        .wdata   (sh_q),
        .raddr   (reg_a),
        .rdata_q (mem_rdata)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q    <= S_IDLE;
            ones_q  <= 6'h00;
            cnt_q   <= 5'h00;
            hdr_q   <= 13'h0000;
            sh_q    <= 16'h0000;
            is_rd_q <= 1'b0;
            mdio_o  <= 1'b0;
            mdio_oe <= 1'b0;
            mem_we  <= 1'b0;
            rd_ev   <= 1'b0;
            wr_ev   <= 1'b0;
        end else begin
            mem_we <= 1'b0;
            rd_ev  <= 1'b0;
            wr_ev  <= 1'b0;
            if (mdc_rise && strap_done_q) begin
                case (st_q)
                    S_IDLE: begin
                        if (mdio_in) begin
                            if (ones_q != `PMIR_PRE_LEN) begin
                                ones_q <= ones_q + 6'h01;
                            end
                        end else begin
                            ones_q <= 6'h00;
                            if (ones_q == `PMIR_PRE_LEN) begin
                                st_q  <= S_HDR;
                                cnt_q <= 5'h00;
                            end
                        end
                    end
                    S_HDR: begin
                        hdr_q <= hdr_n;
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == {1'b0, `PMIR_HDR_LEN} - 5'h01) begin
                            // Start bit, address match and opcode
                            if (hdr_n[12] && hdr_n[9:5] == my_addr
                                && hdr_n[11:10] == `PMIR_OP_READ) begin
                                st_q    <= S_TA;
                                is_rd_q <= 1'b1;
                                rd_ev   <= 1'b1;
                            end else if (hdr_n[12] && hdr_n[9:5] == my_addr
                                && hdr_n[11:10] == `PMIR_OP_WRITE) begin
                                st_q    <= S_TA;
                                is_rd_q <= 1'b0;
                            end else begin
                                st_q <= S_IDLE;
                            end
                            cnt_q <= 5'h00;
                        end
                    end
                    S_TA: begin
                        // First turnaround bit undriven, second driven low
                        st_q  <= is_rd_q ? S_RD : S_TA;
                        cnt_q <= 5'h00;
                        if (is_rd_q) begin
                            mdio_oe <= 1'b1;
                            mdio_o  <= 1'b0;
                            sh_q    <= reg_a == `PMIR_MDIO_REG_INT ? {int_en_q, int_st_q}
                                     : reg_a == `PMIR_MDIO_REG_CTL2
                                     ? {mem_rdata[15], int_pol_q, mem_rdata[13:0]}
                                     : mem_rdata;
                        end else if (cnt_q == 5'h01) begin
                            st_q <= S_WR;
                        end else begin
                            cnt_q <= 5'h01;
                        end
                    end
                    S_RD: begin
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == `PMIR_DATA_LEN) begin
                            mdio_oe <= 1'b0;
                            st_q    <= S_IDLE;
                        end else begin
                            mdio_o <= sh_q[15];
                            sh_q   <= {sh_q[14:0], 1'b0};
                        end
                    end
                    S_WR: begin
                        sh_q  <= {sh_q[14:0], mdio_in};
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == `PMIR_DATA_LEN - 5'h01) begin
                            st_q <= S_DONE;
                        end
                    end
                    default: begin
                        st_q <= S_IDLE;
                    end
                endcase
            end else if (st_q == S_DONE) begin
                mem_we <= 1'b1;
                wr_ev  <= 1'b1;
                st_q   <= S_IDLE;
            end
        end
    end

    // Interrupt conditions and polarity
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_en_q  <= 8'h00;
            int_st_q  <= 8'h00;
            int_pol_q <= 1'b0;
        end else begin
            int_st_q <= (int_rd ? 8'h00 : int_st_q) | phy_evt;
            if (int_wr) begin
                int_en_q <= sh_q[15:8];
            end
            if (pol_wr) begin
                int_pol_q <= sh_q[`PMIR_POL_BIT];
            end
        end
    end

    // Register bus slave
    reg        ctrl_pme_q;
    reg        wake_q;
    reg  [3:0] irq_st_q;
    reg  [3:0] irq_mask_q;
    reg        dwr_q;
    reg  [7:0] daddr_q;
    wire       aphase = hsel && hready && htrans[1];
    wire       bus_wr = dwr_q;
    wire       wake_clr = bus_wr && daddr_q == `PMIR_A_CTRL && hwdata[`PMIR_CTRL_WAKE_CLR];
    wire [3:0] ev = {~strap_done_q & (strap_cnt_q == `PMIR_STRAP_WAIT), wake_evt, rd_ev, wr_ev};
    wire       int_act = |(int_st_q & int_en_q);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hirq      = |(irq_st_q & irq_mask_q);
    assign wake_event_out_oe = 1'b1;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dwr_q      <= 1'b0;
            daddr_q    <= 8'h00;
            hrdata     <= 32'h0000_0000;
            ctrl_pme_q <= 1'b0;
            wake_q     <= 1'b0;
            irq_st_q   <= 4'h0;
            irq_mask_q <= 4'h0;
            wake_event_out <= 1'b1;
        end else begin
            dwr_q   <= aphase && hwrite;
            daddr_q <= haddr[7:0];
            if (aphase && !hwrite) begin
                case (haddr[7:0])
                    `PMIR_A_CTRL:      hrdata <= {30'h0, wake_q, ctrl_pme_q};
                    `PMIR_A_STRAP:     hrdata <= {27'h0, clk_en_strap_q, led_strap_q,
                                                  addr_strap_q};
                    `PMIR_A_IRQ_STAT:  hrdata <= {28'h0, irq_st_q};
                    `PMIR_A_IRQ_MASK:  hrdata <= {28'h0, irq_mask_q};
                    `PMIR_A_INT_STATE: hrdata <= {15'h0, int_pol_q, int_en_q, int_st_q};
                    default:           hrdata <= 32'h0000_0000;
                endcase
            end
            if (bus_wr && daddr_q == `PMIR_A_CTRL) begin
                ctrl_pme_q <= hwdata[`PMIR_CTRL_PME_SEL];
            end
            if (bus_wr && daddr_q == `PMIR_A_IRQ_MASK) begin
                irq_mask_q <= hwdata[3:0];
            end
            irq_st_q <= ((bus_wr && daddr_q == `PMIR_A_IRQ_STAT)
                        ? irq_st_q & ~hwdata[3:0] : irq_st_q) | ev;
            wake_q   <= (wake_q & ~wake_clr) | wake_evt;
            if (ctrl_pme_q) begin
                wake_event_out <= ~wake_q;
            end else begin
                wake_event_out <= int_pol_q ? int_act : ~int_act;
            end
        end
    end
endmodule // pmir_top

// >>> testbench/pmir_top_assertions.sv
`timescale 1ns/1ps
module pmir_chk (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        mdc_i,
    input wire        mdio_o,
    input wire        mdio_oe,
    input wire        wake_event_out_oe,
    input wire        ref_clk_out,
    input wire        ref_clk_out_oe,
    input wire        clk_out_en_strap
);
    reg       mdc_q;
    reg [3:0] since_q;
    reg [3:0] since_d;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles since the last management clock rise
    always @* begin
        since_d = (since_q == 4'hF) ? since_q : since_q + 4'h1;
        if (mdc_i && !mdc_q) since_d = 4'h0;
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdc_q <= 1'b0;
            since_q <= 4'hF;
        end else begin
            mdc_q <= mdc_i;
            since_q <= since_d;
        end
    end
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_pin_driven: assert property (wake_event_out_oe)
        else $error("interrupt pin not driven");
    chk_mdio_on_mdc: assert property
        (($changed(mdio_oe) || (mdio_oe && $changed(mdio_o))) |-> since_d >= 4'h2 && since_d <= 4'h7)
        else $error("data pin moved away from a clock rise");
    chk_mdio_quiet_boot: assert property ($rose(hresetn) |-> !mdio_oe [*6])
        else $error("data pin driven without a clock");
    chk_strap_oe_late: assert property
        ($rose(hresetn) |-> !ref_clk_out_oe [*3] ##[1:6] ref_clk_out_oe)
        else $error("clock pin output enable timing wrong");
    chk_clk_out_quiet: assert property (!ref_clk_out_oe |-> !ref_clk_out)
        else $error("clock pin toggles while an input");
    chk_clk_out_runs: assert property
        (ref_clk_out_oe && $past(ref_clk_out_oe) && clk_out_en_strap
         |-> ref_clk_out != $past(ref_clk_out))
        else $error("reference clock output not toggling");
    chk_ref_rate: assert property
        ($rose(ref_clk_out) |=> $fell(ref_clk_out))
        else $error("reference clock output not at half the core rate");
    chk_clk_out_idle: assert property
        (ref_clk_out_oe && !clk_out_en_strap |-> !ref_clk_out)
        else $error("reference clock output runs while disabled");
    chk_rdata_hold: assert property
        (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
        else $error("read data changed without a read");
endmodule // pmir_chk
bind pmir_top pmir_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .mdc_i, .mdio_o, .mdio_oe, .wake_event_out_oe, .ref_clk_out,
    .ref_clk_out_oe, .clk_out_en_strap);

// >>> testbench/pmir_mac_model.sv
`timescale 1ns/1ps
`include "pmir_consts.vh"
module pmir_mac_model (
    output reg  mdc,
    output reg  mdio_v,
    output reg  mdio_en,
    input  wire mdio_line
);
    initial begin
        mdc = 1'b0;
        mdio_v = 1'b1;
        mdio_en = 1'b0;
    end
    // Clock rests low between frames
    task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd,
               output [15:0] rd);
        reg [63:0] w;
        integer    i;
        begin
            w = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
            #7;
            mdio_en = 1'b1;
            for (i = 63; i >= 0; i = i - 1) begin
                if (op == `PMIR_OP_READ && i < 18) mdio_en = 1'b0;
                mdio_v = w[i];
                #80;
                if (i < 16) rd[i] = mdio_line;
                mdc = 1'b1;
                #80;
                mdc = 1'b0;
            end
            mdio_en = 1'b0;
        end
    endtask
endmodule // pmir_mac_model

// >>> testbench/pmir_top_tb.sv
`timescale 1ns/1ps
`include "pmir_consts.vh"
module pmir_top_tb;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [2:0]  hsize = 3'h2;
    reg  [31:0] hwdata = 32'h0;
    reg  [2:0]  addr_pull = 3'h5;
    reg         en_pull = 1'b1;
    reg         led_pull = 1'b1;
    reg  [7:0]  phy_evt = 8'h0;
    reg         wake_evt = 1'b0;
    wire        hreadyout, hresp, hirq, mdio_o, mdio_oe, wake_event_out, wake_event_out_oe;
    wire        ref_clk_out, ref_clk_out_oe, mdc_i, mac_v, mac_en;
    wire [31:0] hrdata;
    wire        mdio_line = mdio_oe ? mdio_o : (mac_en ? mac_v : 1'b1);
    wire        clk_pin = ref_clk_out_oe ? ref_clk_out : led_pull;
    integer     err_total = 0;
    integer     n_tests = 0;
    reg  [31:0] rd;
    reg  [15:0] md;
    always #10 hclk = ~hclk;
    pmir_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .hirq, .mdc_i, .mdio_i(mdio_line),
        .mdio_o, .mdio_oe, .wake_event_out, .wake_event_out_oe, .ref_clk_in(1'b0),
        .ref_clk_out, .ref_clk_out_oe, .ref_clk_out_i(clk_pin), .mgmt_addr_strap(addr_pull),
        .clk_out_en_strap(en_pull), .phy_evt, .wake_evt);
    pmir_mac_model M (.mdc(mdc_i), .mdio_v(mac_v), .mdio_en(mac_en), .mdio_line(mdio_line));
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task check(input string nm, input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task ahb(input w, input [31:0] a, input [31:0] wd);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rd = hrdata;
        end
    endtask
    task rdc(input string nm, input [31:0] a, input [31:0] exp);
        begin
            ahb(1'b0, a, 32'h0);
            check(nm, rd, exp);
        end
    endtask
    task mdio(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd);
        begin
            M.frame(op, pa, ra, wd, md);
            repeat (4) @(posedge hclk);
        end
    endtask
    task pulse(input [7:0] pe, input we);
        begin
            phy_evt <= pe;
            wake_evt <= we;
            @(posedge hclk);
            phy_evt <= 8'h0;
            wake_evt <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask
    task boot(input [2:0] a, input e, input l);
        begin
            hresetn <= 1'b0;
            addr_pull <= a;
            en_pull <= e;
            led_pull <= l;
            repeat (20) @(posedge hclk);
            hresetn <= 1'b1;
            repeat (8) @(posedge hclk);
        end
    endtask
    initial begin
        #500000;
        err_total = err_total + 1;
        finish_test;
    end
    initial begin
        boot(3'h5, 1'b1, 1'b1);
        rdc("strap", `PMIR_A_STRAP, 32'h1D);
        rdc("stat", `PMIR_A_IRQ_STAT, 32'h8);
        check("irq_off", {31'h0, hirq}, 32'h0);
        ahb(1'b1, `PMIR_A_IRQ_MASK, 32'h8);
        @(posedge hclk);
        check("irq_on", {31'h0, hirq}, 32'h1);
        ahb(1'b1, `PMIR_A_IRQ_STAT, 32'h8);
        @(posedge hclk);
        check("irq_clr", {31'h0, hirq}, 32'h0);
        rdc("unmapped", 32'h20, 32'h0);
        $display("test strap_irq done");
        mdio(`PMIR_OP_WRITE, 5'h05, `PMIR_MDIO_REG_CTL2, 16'h4000);
        mdio(`PMIR_OP_WRITE, 5'h05, `PMIR_MDIO_REG_INT, 16'hFF00);
        pulse(8'h01, 1'b0);
        check("pin_high", {31'h0, wake_event_out}, 32'h1);
        rdc("int_state", `PMIR_A_INT_STATE, 32'h1FF01);
        mdio(`PMIR_OP_READ, 5'h05, `PMIR_MDIO_REG_INT, 16'h0);
        check("int_reg", {16'h0, md}, 32'hFF01);
        check("pin_low", {31'h0, wake_event_out}, 32'h0);
        mdio(`PMIR_OP_WRITE, 5'h0D, `PMIR_MDIO_REG_CTL2, 16'h0);
        mdio(`PMIR_OP_READ, 5'h05, `PMIR_MDIO_REG_CTL2, 16'h0);
        check("ctl2", {16'h0, md}, 32'h4000);
        mdio(`PMIR_OP_READ, 5'h0D, `PMIR_MDIO_REG_CTL2, 16'h0);
        check("foreign", {16'h0, md}, 32'hFFFF);
        rdc("stat2", `PMIR_A_IRQ_STAT, 32'h3);
        mdio(`PMIR_OP_WRITE, 5'h05, `PMIR_MDIO_REG_CTL2, 16'h0);
        check("pin_idle", {31'h0, wake_event_out}, 32'h1);
        $display("test mdio done");
        ahb(1'b1, `PMIR_A_IRQ_STAT, 32'hF);
        ahb(1'b1, `PMIR_A_IRQ_MASK, 32'h4);
        ahb(1'b1, `PMIR_A_CTRL, 32'h1);
        @(posedge hclk);
        check("wake_idle", {31'h0, wake_event_out}, 32'h1);
        pulse(8'h0, 1'b1);
        check("wake_pin", {31'h0, wake_event_out}, 32'h0);
        check("wake_irq", {31'h0, hirq}, 32'h1);
        rdc("ctrl", `PMIR_A_CTRL, 32'h3);
        ahb(1'b1, `PMIR_A_CTRL, 32'h3);
        @(posedge hclk);
        @(posedge hclk);
        check("wake_clr", {31'h0, wake_event_out}, 32'h1);
        rdc("ctrl2", `PMIR_A_CTRL, 32'h1);
        $display("test wake done");
        boot(3'h2, 1'b0, 1'b0);
        rdc("strap2", `PMIR_A_STRAP, 32'h02);
        repeat (10) @(posedge hclk);
        $display("test reboot done");
        finish_test;
    end
endmodule // pmir_top_tb
